/* include/ext_irq_ctrl_pkg.sv */
// constants, field layout and types of the external pin interrupt controller
// What this block does
// RULE1: eight external pins plus one non-maskable input, each with own detection path
// RULE2: sense picks rising, falling, both, high or low; zero disables the flag
// RULE3: edge mode sets the flag again only on a fresh edge
// RULE4: level mode sets the flag again at once if the level persists
// RULE5: filter enable routes the pin through a majority filter on detector ticks
// RULE6: filter takes three detector samples and outputs one when two are one
// RULE7: unfiltered level detection needs no detector tick
// RULE8: filter or edge mode on the non-maskable input, or on a pin while enabled, raises the detector clock request
// RULE9: latency bounded: 3 bus clocks level, plus 4 or 6 detector clocks
// RULE10: writing one to enable turns the controller on, zero turns it off
// RULE11: writing one to soft reset restores every register and disables
// RULE12: software enables clocks and writes configuration before the enable bit
// RULE13: software writes non-maskable control before starting the detector clock
// RULE14: non-maskable input has its own sense field and filter enable
// RULE15: non-maskable detection depends only on its sense, not on the enable bit
// RULE16: after any reset the non-maskable sense is no detection
// RULE17: non-maskable detection sets its flag, which always drives its request
// RULE18: two requests: one shared by eight pins, one for non-maskable input
// RULE19: events to the routing system are single pulses
// RULE20: keeps working in sleep while its clock runs; requests can wake
// RULE21: all writable registers but the two flag registers honour write protection
// RULE22: enable and soft reset writes are synchronised to the detector timing
// RULE23: enable-set and enable-clear registers; request is flag and enable
// RULE24: pin request holds until flag cleared, enable removed or reset
// RULE25: per-pin event enable lets a match emit an event pulse
// RULE26: per-pin wake enable lets a match wake the device
// RULE27: writing one to a flag bit clears it, zero leaves it
package ext_irq_ctrl_pkg;
  localparam int NUM_PINS = 8;
  localparam int NUM_CH = 9;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h01;
  localparam logic [7:0] OFS_NMCTRL = 8'h02;
  localparam logic [7:0] OFS_NMFLAG = 8'h03;
  localparam logic [7:0] OFS_EVENT_OUTPUT_CONTROL = 8'h04;
  localparam logic [7:0] OFS_ENCLR = 8'h08;
  localparam logic [7:0] OFS_ENSET = 8'h0C;
  localparam logic [7:0] OFS_FLAG = 8'h10;
  localparam logic [7:0] OFS_WAKE = 8'h14;
  localparam logic [7:0] OFS_CONFIG = 8'h18;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int BIT_SOFT_RESET_BIT = 0;
  localparam int BIT_ENABLE = 1;
  localparam int BIT_SYNCBUSY = 7;
  localparam int CFG_BITS = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_CONFIG = 32'h0000_0000;
  localparam logic [3:0] RST_NMCTRL = 4'h0;
  // ****************************************
  // detector timing
  // ****************************************
  localparam int CORE_HZ = 40_000_000;
  localparam int DET_HZ = 10_000_000;
  localparam int DET_DIV = CORE_HZ / DET_HZ;
  localparam logic [3:0] DET_LAST = 4'(DET_DIV - 1);
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    SENSE_NONE = 3'h0,
    SENSE_RISE = 3'h1,
    SENSE_FALL = 3'h2,
    SENSE_BOTH = 3'h3,
    SENSE_HIGH = 3'h4,
    SENSE_LOW = 3'h5
  } sense_e;
  typedef struct packed {
    logic filt;
    logic [2:0] sense;
  } pin_cfg_s;
endpackage

/* rtl/ext_irq_ctrl.sv */
// external pin interrupt controller: detection, flags, requests, events, registers
`timescale 1ns/1ps
module ext_irq_ctrl (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] extIrqPin,
  input wire logic nonmaskPin,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  input wire logic writeProtect,
  input wire logic debugAccess,
  output logic extIrqReq,
  output logic nonmaskIrqReq,
  output logic [7:0] eventPulse,
  output logic wakeReq,
  output logic detClockReq
);
  // ****************************************
  // detector tick divider
  // ****************************************
  logic [3:0] divCnt_r;
  logic [3:0] divCnt_nxt;
  logic detTick;

  always_comb begin
    divCnt_nxt = (divCnt_r == ext_irq_ctrl_pkg::DET_LAST) ? 4'h0 : divCnt_r + 4'h1;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      divCnt_r <= 4'h0;
    end else begin
      divCnt_r <= divCnt_nxt;
    end
  end

  assign detTick = (divCnt_r == ext_irq_ctrl_pkg::DET_LAST);

  // ****************************************
  // registers
  // ****************************************
  logic ctrlEn_r, ctrlEn_nxt;
  logic swrstPend_r, swrstPend_nxt;
  logic enPend_r, enPend_nxt;
  logic enVal_r, enVal_nxt;
  logic [3:0] nmCtrl_r, nmCtrl_nxt;
  logic nmFlag_r, nmFlag_nxt;
  logic [7:0] evEn_r, evEn_nxt;
  logic [7:0] irqEn_r, irqEn_nxt;
  logic [7:0] flag_r, flag_nxt;
  logic [7:0] wakeEn_r, wakeEn_nxt;
  logic [31:0] cfg_r, cfg_nxt;
  logic [31:0] rdData_r, rdData_nxt;
  logic syncBusy;
  logic wrOk;
  logic swrstApply;
  logic [8:0] chSet;
  logic [8:0] chMatch;
  logic [8:0] allPins;
  ext_irq_ctrl_pkg::pin_cfg_s chCfg [9];

  assign syncBusy = swrstPend_r | enPend_r;
  // flag registers are outside the protection; debugger writes bypass it
  assign wrOk = regWrite & (~writeProtect | debugAccess); // RULE21
  assign swrstApply = swrstPend_r & detTick; // RULE22
  assign allPins = {nonmaskPin, extIrqPin}; // RULE1

  always_comb begin
    ctrlEn_nxt = ctrlEn_r;
    swrstPend_nxt = swrstPend_r;
    enPend_nxt = enPend_r;
    enVal_nxt = enVal_r;
    nmCtrl_nxt = nmCtrl_r;
    evEn_nxt = evEn_r;
    irqEn_nxt = irqEn_r;
    wakeEn_nxt = wakeEn_r;
    cfg_nxt = cfg_r;
    // set wins over a clear arriving in the same cycle
    flag_nxt = flag_r;
    nmFlag_nxt = nmFlag_r;
    if (regWrite && regAddr == ext_irq_ctrl_pkg::OFS_FLAG) begin
      flag_nxt = flag_r & ~regWrData[7:0]; // RULE27
    end
    if (regWrite && regAddr == ext_irq_ctrl_pkg::OFS_NMFLAG) begin
      nmFlag_nxt = nmFlag_r & ~regWrData[0]; // RULE27
    end
    flag_nxt = flag_nxt | chSet[7:0]; // RULE3 RULE4
    nmFlag_nxt = nmFlag_nxt | chSet[8]; // RULE17
    // enable lands on a tick; a control write in that same cycle stays pending
    if (enPend_r && detTick) begin
      ctrlEn_nxt = enVal_r; // RULE10 RULE22
      enPend_nxt = 1'b0;
    end
    if (wrOk) begin
      case (regAddr)
        ext_irq_ctrl_pkg::OFS_CTRL: begin
          if (regWrData[ext_irq_ctrl_pkg::BIT_SOFT_RESET_BIT]) begin
            swrstPend_nxt = 1'b1; // RULE11
          end else begin
            enPend_nxt = 1'b1; // RULE10
            enVal_nxt = regWrData[ext_irq_ctrl_pkg::BIT_ENABLE];
          end
        end
        ext_irq_ctrl_pkg::OFS_NMCTRL: nmCtrl_nxt = regWrData[3:0]; // RULE14
        ext_irq_ctrl_pkg::OFS_EVENT_OUTPUT_CONTROL: evEn_nxt = regWrData[7:0];
        ext_irq_ctrl_pkg::OFS_ENCLR: irqEn_nxt = irqEn_r & ~regWrData[7:0]; // RULE23
        ext_irq_ctrl_pkg::OFS_ENSET: irqEn_nxt = irqEn_r | regWrData[7:0]; // RULE23
        ext_irq_ctrl_pkg::OFS_WAKE: wakeEn_nxt = regWrData[7:0];
        ext_irq_ctrl_pkg::OFS_CONFIG: cfg_nxt = regWrData;
        default: cfg_nxt = cfg_r;
      endcase
    end
    if (swrstApply) begin
      ctrlEn_nxt = 1'b0; // RULE11
      swrstPend_nxt = 1'b0;
      enPend_nxt = 1'b0;
      enVal_nxt = 1'b0;
      nmCtrl_nxt = ext_irq_ctrl_pkg::RST_NMCTRL; // RULE16
      nmFlag_nxt = 1'b0;
      evEn_nxt = ext_irq_ctrl_pkg::RST_BYTE;
      irqEn_nxt = ext_irq_ctrl_pkg::RST_BYTE;
      flag_nxt = ext_irq_ctrl_pkg::RST_BYTE;
      wakeEn_nxt = ext_irq_ctrl_pkg::RST_BYTE;
      cfg_nxt = ext_irq_ctrl_pkg::RST_CONFIG;
    end
  end

  always_comb begin
    rdData_nxt = 32'h0000_0000;
    if (regRead) begin
      case (regAddr)
        ext_irq_ctrl_pkg::OFS_CTRL: rdData_nxt = {30'h0000_0000, ctrlEn_r, swrstPend_r};
        ext_irq_ctrl_pkg::OFS_STATUS: rdData_nxt = {24'h00_0000, syncBusy, 7'h00};
        ext_irq_ctrl_pkg::OFS_NMCTRL: rdData_nxt = {28'h000_0000, nmCtrl_r};
        ext_irq_ctrl_pkg::OFS_NMFLAG: rdData_nxt = {31'h0000_0000, nmFlag_r};
        ext_irq_ctrl_pkg::OFS_EVENT_OUTPUT_CONTROL: rdData_nxt = {24'h00_0000, evEn_r};
        ext_irq_ctrl_pkg::OFS_ENCLR: rdData_nxt = {24'h00_0000, irqEn_r};
        ext_irq_ctrl_pkg::OFS_ENSET: rdData_nxt = {24'h00_0000, irqEn_r};
        ext_irq_ctrl_pkg::OFS_FLAG: rdData_nxt = {24'h00_0000, flag_r};
        ext_irq_ctrl_pkg::OFS_WAKE: rdData_nxt = {24'h00_0000, wakeEn_r};
        ext_irq_ctrl_pkg::OFS_CONFIG: rdData_nxt = cfg_r;
        default: rdData_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrlEn_r <= 1'b0;
      swrstPend_r <= 1'b0;
      enPend_r <= 1'b0;
      enVal_r <= 1'b0;
      nmCtrl_r <= ext_irq_ctrl_pkg::RST_NMCTRL; // RULE16
      nmFlag_r <= 1'b0;
      evEn_r <= ext_irq_ctrl_pkg::RST_BYTE;
      irqEn_r <= ext_irq_ctrl_pkg::RST_BYTE;
      flag_r <= ext_irq_ctrl_pkg::RST_BYTE;
      wakeEn_r <= ext_irq_ctrl_pkg::RST_BYTE;
      cfg_r <= ext_irq_ctrl_pkg::RST_CONFIG;
      rdData_r <= 32'h0000_0000;
    end else begin
      ctrlEn_r <= ctrlEn_nxt;
      swrstPend_r <= swrstPend_nxt;
      enPend_r <= enPend_nxt;
      enVal_r <= enVal_nxt;
      nmCtrl_r <= nmCtrl_nxt;
      nmFlag_r <= nmFlag_nxt;
      evEn_r <= evEn_nxt;
      irqEn_r <= irqEn_nxt;
      flag_r <= flag_nxt;
      wakeEn_r <= wakeEn_nxt;
      cfg_r <= cfg_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;

  // ****************************************
  // per-channel detection, channel 8 is non-maskable
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < ext_irq_ctrl_pkg::NUM_CH; g++) begin : gCh
      logic [1:0] sync_r, sync_nxt;
      logic [2:0] samp_r, samp_nxt;
      logic prev_r, prev_nxt;
      logic filtVal, srcVal, rise, fall, match, chOn;

      if (g < ext_irq_ctrl_pkg::NUM_PINS) begin : gPin
        assign chCfg[g] = cfg_r[g*ext_irq_ctrl_pkg::CFG_BITS +: ext_irq_ctrl_pkg::CFG_BITS];
        assign chOn = ctrlEn_r;
      end else begin : gNm
        assign chCfg[g] = nmCtrl_r; // RULE14
        assign chOn = 1'b1; // RULE15
      end

      // majority of the three latest detector samples
      assign filtVal = (samp_r[0] & samp_r[1]) | (samp_r[1] & samp_r[2]) | (samp_r[0] & samp_r[2]); // RULE6
      assign srcVal = chCfg[g].filt ? filtVal : sync_r[1]; // RULE5
      assign rise = detTick & srcVal & ~prev_r;
      assign fall = detTick & ~srcVal & prev_r;

      always_comb begin
        sync_nxt = {sync_r[0], allPins[g]};
        samp_nxt = detTick ? {samp_r[1:0], sync_r[1]} : samp_r; // RULE6
        prev_nxt = detTick ? srcVal : prev_r;
        case (chCfg[g].sense)
          ext_irq_ctrl_pkg::SENSE_RISE: match = rise; // RULE2 RULE3
          ext_irq_ctrl_pkg::SENSE_FALL: match = fall;
          ext_irq_ctrl_pkg::SENSE_BOTH: match = rise | fall;
          // level path runs every cycle, no detector tick needed when unfiltered
          ext_irq_ctrl_pkg::SENSE_HIGH: match = srcVal; // RULE4 RULE7
          ext_irq_ctrl_pkg::SENSE_LOW: match = ~srcVal;
          default: match = 1'b0; // RULE2
        endcase
      end

      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          sync_r <= 2'h0;
          samp_r <= 3'h0;
          prev_r <= 1'b0;
        end else begin
          sync_r <= sync_nxt;
          samp_r <= samp_nxt;
          prev_r <= prev_nxt;
        end
      end

      assign chMatch[g] = match & chOn;
      assign chSet[g] = match & chOn;

      a_level_latency: // RULE9
      assert property (@(posedge core_clk) disable iff (reset)
        (chOn && !chCfg[g].filt && chCfg[g].sense == ext_irq_ctrl_pkg::SENSE_HIGH && allPins[g] && !swrstPend_r)[*3]
        |=> (g < 8 ? flag_r[g % 8] : nmFlag_r))
        else $error("unfiltered level not flagged within three clocks");
      a_sense_off: // RULE2
      assert property (@(posedge core_clk) disable iff (reset)
        (chCfg[g].sense == ext_irq_ctrl_pkg::SENSE_NONE) |-> !chSet[g])
        else $error("disabled sense produced a detection");
      a_edge_on_tick: // RULE3
      assert property (@(posedge core_clk) disable iff (reset)
        (chSet[g] && chCfg[g].sense inside {ext_irq_ctrl_pkg::SENSE_RISE, ext_irq_ctrl_pkg::SENSE_FALL})
        |-> detTick && (srcVal != $past(srcVal, 4)))
        else $error("edge detected without a fresh edge");
    end
  endgenerate

  // ****************************************
  // requests, events, wake, clock request
  // ****************************************
  logic [7:0] matchPrev_r, matchPrev_nxt;
  logic [7:0] event_r, event_nxt;
  logic anyDetNeed;

  always_comb begin
    matchPrev_nxt = chMatch[7:0];
    // pulse on the first cycle of a match, so a held level gives one event
    event_nxt = evEn_r & chMatch[7:0] & ~matchPrev_r; // RULE19 RULE25
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      matchPrev_r <= 8'h00;
      event_r <= 8'h00;
    end else begin
      matchPrev_r <= matchPrev_nxt;
      event_r <= event_nxt;
    end
  end

  always_comb begin
    anyDetNeed = 1'b0;
    for (int i = 0; i < ext_irq_ctrl_pkg::NUM_CH; i++) begin
      if (chCfg[i].filt || chCfg[i].sense inside {ext_irq_ctrl_pkg::SENSE_RISE, ext_irq_ctrl_pkg::SENSE_FALL,
          ext_irq_ctrl_pkg::SENSE_BOTH}) begin
        anyDetNeed = (i == 8) || ctrlEn_r; // RULE8
      end
    end
  end

  assign eventPulse = event_r;
  assign extIrqReq = |(flag_r & irqEn_r); // RULE18 RULE23 RULE24
  assign nonmaskIrqReq = nmFlag_r; // RULE17 RULE18
  // wake works off the same core clock that keeps running in sleep
  assign wakeReq = |(chMatch[7:0] & wakeEn_r) | nonmaskIrqReq | extIrqReq; // RULE20 RULE26
  assign detClockReq = anyDetNeed; // RULE8

  // ****************************************
  // checks
  // ****************************************
  a_flag_set_wins: // RULE27
  assert property (@(posedge core_clk) disable iff (reset)
    (chSet[0] && regWrite && regAddr == ext_irq_ctrl_pkg::OFS_FLAG && regWrData[0] && !swrstApply) |=> flag_r[0])
    else $error("flag set lost against clear");
  a_flag_clear_one: // RULE27
  assert property (@(posedge core_clk) disable iff (reset)
    (flag_r[1] && !(regWrite && regAddr == ext_irq_ctrl_pkg::OFS_FLAG && regWrData[1]) && !swrstApply) |=> flag_r[1])
    else $error("flag dropped without a one written");
  a_irq_held: // RULE24
  assert property (@(posedge core_clk) disable iff (reset)
    (extIrqReq && !regWrite && !swrstApply) |=> extIrqReq)
    else $error("pin request dropped without clear, disable or reset");
  a_nonmask_held: // RULE17
  assert property (@(posedge core_clk) disable iff (reset)
    (nmFlag_r && !(regWrite && regAddr == ext_irq_ctrl_pkg::OFS_NMFLAG) && !swrstApply) |=> nonmaskIrqReq)
    else $error("non-maskable request dropped");
  a_event_single: // RULE19
  assert property (@(posedge core_clk) disable iff (reset)
    |eventPulse |=> ((eventPulse & $past(eventPulse)) == 8'h00))
    else $error("event longer than one cycle");
  a_protect_blocks: // RULE21
  assert property (@(posedge core_clk) disable iff (reset)
    (regWrite && writeProtect && !debugAccess && regAddr == ext_irq_ctrl_pkg::OFS_WAKE && !swrstApply)
    |=> $stable(wakeEn_r))
    else $error("protected write changed a register");
  a_soft_reset_bit_clears: // RULE11
  assert property (@(posedge core_clk) disable iff (reset)
    swrstApply |=> !ctrlEn_r && nmCtrl_r == 4'h0 && cfg_r == 32'h0000_0000 && irqEn_r == 8'h00)
    else $error("soft reset left state behind");
  a_sync_bound: // RULE22
  assert property (@(posedge core_clk) disable iff (reset)
    $rose(syncBusy) |-> ##[1:5] !syncBusy)
    else $error("enable or soft reset not applied within one detector period");
  a_enable_applies: // RULE10
  assert property (@(posedge core_clk) disable iff (reset)
    (enPend_r && detTick && !swrstPend_r) |=> ctrlEn_r == $past(enVal_r))
    else $error("enable write not applied");
  a_pins_gated: // RULE10
  assert property (@(posedge core_clk) disable iff (reset)
    !ctrlEn_r |=> (flag_r & ~$past(flag_r)) == 8'h00)
    else $error("disabled controller raised a pin flag");
  a_soft_reset_bit_all: // RULE11 RULE16
  assert property (@(posedge core_clk) disable iff (reset)
    swrstApply |=> nmCtrl_r == ext_irq_ctrl_pkg::RST_NMCTRL && !nmFlag_r && flag_r == 8'h00 && evEn_r == 8'h00
      && wakeEn_r == 8'h00 && !syncBusy)
    else $error("soft reset left a register set");
  a_event_gated: // RULE25
  assert property (@(posedge core_clk) disable iff (reset)
    (eventPulse & ~$past(evEn_r)) == 8'h00)
    else $error("event from a pin with its event output off");
  a_event_first: // RULE19 RULE25
  assert property (@(posedge core_clk) disable iff (reset)
    (evEn_r[0] && chMatch[0] && !matchPrev_r[0]) |=> eventPulse[0])
    else $error("pin match gave no event");
  a_enclr_clears: // RULE23
  assert property (@(posedge core_clk) disable iff (reset)
    (wrOk && regAddr == ext_irq_ctrl_pkg::OFS_ENCLR) |=> (irqEn_r & $past(regWrData[7:0])) == 8'h00)
    else $error("enable clear left an enable set");
  a_enset_sets: // RULE23
  assert property (@(posedge core_clk) disable iff (reset)
    (wrOk && regAddr == ext_irq_ctrl_pkg::OFS_ENSET && !swrstApply)
    |=> (~irqEn_r & $past(regWrData[7:0])) == 8'h00)
    else $error("enable set did not set");
  a_busy_on_ctrl: // RULE22
  assert property (@(posedge core_clk) disable iff (reset)
    (wrOk && regAddr == ext_irq_ctrl_pkg::OFS_CTRL && !swrstApply) |=> syncBusy)
    else $error("control write not marked busy");
  a_clock_request: // RULE8
  assert property (@(posedge core_clk) disable iff (reset)
    (nmCtrl_r[3] || (ctrlEn_r && cfg_r[3])) |-> detClockReq)
    else $error("filter on without detector clock request");
  a_nm_clear: // RULE27
  assert property (@(posedge core_clk) disable iff (reset)
    (regWrite && regAddr == ext_irq_ctrl_pkg::OFS_NMFLAG && regWrData[0] && !chSet[8]) |=> !nmFlag_r)
    else $error("non-maskable flag not cleared by a one");
  a_pin_clear: // RULE27
  assert property (@(posedge core_clk) disable iff (reset)
    (regWrite && regAddr == ext_irq_ctrl_pkg::OFS_FLAG && regWrData[2] && !chSet[2]) |=> !flag_r[2])
    else $error("pin flag not cleared by a one");
endmodule

/* tb/pin_partner.sv */
// behavioural model of the external pins and of the event routing side
`timescale 1ns/1ps
module pin_partner (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] eventPulse,
  output logic [7:0] extIrqPin,
  output logic nonmaskPin,
  output int pulseCount
);
  // ****************************************
  // pin drive
  // ****************************************
  initial begin
    extIrqPin = 8'h00;
    nonmaskPin = 1'b0;
  end
  // changes land just after an edge, so the two-flop capture never races
  task automatic setPins(input logic [7:0] p, input logic n);
    @(posedge core_clk);
    extIrqPin <= p;
    nonmaskPin <= n;
  endtask
  // ****************************************
  // event sink
  // ****************************************
  // a held level must count once, so every high cycle is one event
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pulseCount <= 0;
    end else begin
      pulseCount <= pulseCount + $countones(eventPulse);
    end
  end
endmodule

/* tb/tb_top.sv */
// self-checking bench for the external pin interrupt controller
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [3:0] cfg;
    logic pre;
    logic post;
    logic hit;
  } row_s;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic writeProtect = 1'b0;
  logic debugAccess = 1'b0;
  logic [31:0] regRdData;
  logic [7:0] extIrqPin;
  logic nonmaskPin;
  logic extIrqReq;
  logic nonmaskIrqReq;
  logic [7:0] eventPulse;
  logic wakeReq;
  logic detClockReq;
  int pulseCount;
  int errTotal = 0;
  int totalChecks = 0;
  int base;
  logic [7:0] hitMask;
  // sense/filter, level before, level after, flag expected
  row_s rows [16] = '{7'h02, 7'h0B, 7'h0C, 7'h15, 7'h12, 7'h1B, 7'h1D, 7'h23,
                      7'h2D, 7'h32, 7'h3C, 7'h4B, 7'h55, 7'h5D, 7'h63, 7'h6D};
  logic [7:0] regList [9] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20};

  always #12.5 core_clk = ~core_clk;

  ext_irq_ctrl uut (.core_clk(core_clk), .reset(reset), .extIrqPin(extIrqPin), .nonmaskPin(nonmaskPin),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .writeProtect(writeProtect), .debugAccess(debugAccess), .extIrqReq(extIrqReq),
    .nonmaskIrqReq(nonmaskIrqReq), .eventPulse(eventPulse), .wakeReq(wakeReq), .detClockReq(detClockReq));
  pin_partner pp (.core_clk(core_clk), .reset(reset), .eventPulse(eventPulse), .extIrqPin(extIrqPin),
    .nonmaskPin(nonmaskPin), .pulseCount(pulseCount));

  // ****************************************
  // helpers
  // ****************************************
  task automatic endSim();
    $display("Checks %0d, errors %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  // data is only valid in the cycle after the strobe
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    chk(nm, regRdData, exp);
  endtask
  // configuration is only written while disabled
  task automatic setup(input logic [3:0] cfg);
    wr(ext_irq_ctrl_pkg::OFS_CTRL, 32'h0000_0000);
    cyc(8);
    wr(ext_irq_ctrl_pkg::OFS_CONFIG, {8{cfg}});
    wr(ext_irq_ctrl_pkg::OFS_NMCTRL, {28'h0, cfg});
    wr(ext_irq_ctrl_pkg::OFS_CTRL, 32'h0000_0002);
    cyc(8);
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    errTotal++;
    endSim();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    wr(ext_irq_ctrl_pkg::OFS_EVENT_OUTPUT_CONTROL, 32'h0000_00FF);
    wr(ext_irq_ctrl_pkg::OFS_ENSET, 32'h0000_00FF);
    foreach (rows[i]) begin
      hitMask = {8{rows[i].hit}};
      setup(rows[i].cfg);
      pp.setPins({8{rows[i].pre}}, rows[i].pre);
      cyc(40);
      chk("detClockReq", 32'(detClockReq), 32'(rows[i].cfg[3] | (rows[i].cfg[2:0] inside {3'h1, 3'h2, 3'h3})));
      wr(ext_irq_ctrl_pkg::OFS_FLAG, 32'h0000_00FF);
      wr(ext_irq_ctrl_pkg::OFS_NMFLAG, 32'h0000_0001);
      base = pulseCount;
      pp.setPins({8{rows[i].post}}, rows[i].post);
      cyc(40);
      rdChk("flags", ext_irq_ctrl_pkg::OFS_FLAG, {24'h0, hitMask});
      rdChk("nmFlag", ext_irq_ctrl_pkg::OFS_NMFLAG, {31'h0, rows[i].hit});
      chk("extIrqReq", 32'(extIrqReq), 32'(rows[i].hit));
      chk("nonmaskIrqReq", 32'(nonmaskIrqReq), 32'(rows[i].hit));
      chk("events", 32'(pulseCount - base), rows[i].hit ? 32'h8 : 32'h0);
      wr(ext_irq_ctrl_pkg::OFS_FLAG, 32'h0000_00FF);
      rdChk("reflag", ext_irq_ctrl_pkg::OFS_FLAG, {24'h0, hitMask & {8{rows[i].cfg[2]}}});
    end
    // protection, masking and clear on a held rising edge
    setup(4'h1);
    pp.setPins(8'hFF, 1'b0);
    cyc(40);
    chk("reqOn", 32'(extIrqReq), 32'h1);
    writeProtect <= 1'b1;
    wr(ext_irq_ctrl_pkg::OFS_ENCLR, 32'h0000_00FF);
    rdChk("enProt", ext_irq_ctrl_pkg::OFS_ENSET, 32'h0000_00FF);
    debugAccess <= 1'b1;
    wr(ext_irq_ctrl_pkg::OFS_ENCLR, 32'h0000_00FF);
    debugAccess <= 1'b0;
    rdChk("enDbg", ext_irq_ctrl_pkg::OFS_ENCLR, 32'h0000_0000);
    chk("reqOff", 32'(extIrqReq), 32'h0);
    wr(ext_irq_ctrl_pkg::OFS_FLAG, 32'h0000_00FF);
    writeProtect <= 1'b0;
    rdChk("flagProt", ext_irq_ctrl_pkg::OFS_FLAG, 32'h0000_0000);
    // wake needs its own enable
    setup(4'h4);
    wr(ext_irq_ctrl_pkg::OFS_NMFLAG, 32'h0000_0001);
    wr(ext_irq_ctrl_pkg::OFS_WAKE, 32'h0000_0000);
    cyc(4);
    chk("wakeOff", 32'(wakeReq), 32'h0);
    wr(ext_irq_ctrl_pkg::OFS_WAKE, 32'h0000_0001);
    cyc(4);
    chk("wakeOn", 32'(wakeReq), 32'h1);
    // disabled controller ignores pins, the non-maskable input does not
    wr(ext_irq_ctrl_pkg::OFS_CTRL, 32'h0000_0000);
    cyc(8);
    wr(ext_irq_ctrl_pkg::OFS_FLAG, 32'h0000_00FF);
    cyc(8);
    rdChk("offFlags", ext_irq_ctrl_pkg::OFS_FLAG, 32'h0000_0000);
    pp.setPins(8'hFF, 1'b1);
    cyc(8);
    chk("nmOff", 32'(nonmaskIrqReq), 32'h1);
    // unfiltered level latency
    pp.setPins(8'h00, 1'b0);
    wr(ext_irq_ctrl_pkg::OFS_NMFLAG, 32'h0000_0001);
    wr(ext_irq_ctrl_pkg::OFS_ENSET, 32'h0000_00FF);
    setup(4'h4);
    wr(ext_irq_ctrl_pkg::OFS_FLAG, 32'h0000_00FF);
    pp.setPins(8'h01, 1'b0);
    cyc(3);
    #1;
    chk("latency", 32'(extIrqReq), 32'h1);
    // a one-cycle glitch loses the majority vote
    setup(4'hC);
    pp.setPins(8'h00, 1'b0);
    cyc(40);
    wr(ext_irq_ctrl_pkg::OFS_FLAG, 32'h0000_00FF);
    pp.setPins(8'hFF, 1'b0);
    pp.setPins(8'h00, 1'b0);
    cyc(40);
    rdChk("glitch", ext_irq_ctrl_pkg::OFS_FLAG, 32'h0000_0000);
    // soft reset with state everywhere
    pp.setPins(8'h00, 1'b1);
    cyc(40);
    wr(ext_irq_ctrl_pkg::OFS_CTRL, 32'h0000_0001);
    cyc(8);
    foreach (regList[k]) begin
      rdChk("afterSoftReset", regList[k], 32'h0000_0000);
    end
    chk("nmReq", 32'(nonmaskIrqReq), 32'h0);
    chk("extReq", 32'(extIrqReq), 32'h0);
    endSim();
  end
endmodule
